// File: common/gpmc_map.svh
// Purpose: constants of the power-mode controller
// Assumes: 40 MHz system clock
// Notes:   times in their own unit, counts derived from the clock rate
`ifndef GPMC_MAP_SVH
`define GPMC_MAP_SVH
`define GPMC_CLK_HZ          40000000
`define GPMC_CUR_W           16
`define GPMC_DLY_W           16
// stretch of the host line while waking from deep idle, longest, in us
`define GPMC_STRETCH_US      4000
`define GPMC_STRETCH_CYC     ((`GPMC_STRETCH_US * (`GPMC_CLK_HZ / 1000000)))
// oscillator settle wait after restart, least, in us (must fit the stretch)
`define GPMC_OSC_SETTLE_US   2500
`define GPMC_OSC_SETTLE_CYC  (`GPMC_OSC_SETTLE_US * (`GPMC_CLK_HZ / 1000000))
// measurement period in full mode and in idle modes, in us
`define GPMC_FULL_PER_US     1000
`define GPMC_FULL_PER_CYC    ((`GPMC_FULL_PER_US * (`GPMC_CLK_HZ / 1000000)))
`define GPMC_IDLE_PER_US     20000
`define GPMC_IDLE_PER_CYC    ((`GPMC_IDLE_PER_US * (`GPMC_CLK_HZ / 1000000)))
// deep-idle countdown tick, in us
`define GPMC_TICK_US         1000
`define GPMC_TICK_CYC        ((`GPMC_TICK_US * (`GPMC_CLK_HZ / 1000000)))
`define GPMC_CNT_W           24
`endif

// File: common/gpmc_pkg.sv
// Purpose: types of the power-mode controller
// Assumes: gpmc_map.svh included first
// Notes:   mode codes are one-hot
`include "gpmc_map.svh"
package gpmc_pkg;
   typedef enum logic [4:0] {
      GPMC_FULL  = 5'h01,
      GPMC_CAL   = 5'h02,
      GPMC_IDLE  = 5'h04,
      GPMC_DEEP  = 5'h08,
      GPMC_WAKE  = 5'h10
   } gpmc_mode_type;

   typedef struct packed {
      logic                    idle_en;
      logic [`GPMC_CUR_W-1:0]  low_cur_thresh;
      logic [`GPMC_DLY_W-1:0]  deep_idle_delay;
   } gpmc_cfg_type;

   typedef struct packed {
      logic                    mode_full;
      logic                    mode_idle;
      logic                    mode_deep;
      logic                    hf_osc_en;
      logic                    cal_start;
      logic                    meas_strobe;
      logic                    line_hold_oe_n;
      logic                    deep_idle_flag;
   } gpmc_stat_type;
endpackage

// File: core/gpmc_tick.sv
// Purpose: divider giving a one-cycle enable every period cycles
// Assumes: period of at least one cycle
// Notes:   restarts on clear so a mode change begins a fresh period
`timescale 1ns/1ps
`default_nettype none
`include "gpmc_map.svh"
module gpmc_tick
   import gpmc_pkg::*;
#(
   parameter logic [`GPMC_CNT_W-1:0] PERIOD = `GPMC_CNT_W'(`GPMC_TICK_CYC)
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // control
   input  wire logic clear,
   output var  logic tick
);
   typedef struct packed {
      logic [`GPMC_CNT_W-1:0] cnt;
      logic                   tick;
   } gpmc_tick_state_type;

   gpmc_tick_state_type state_reg, state_next;

   always_comb begin
      state_next = state_reg;
      state_next.tick = 1'b0;
      if (clear) begin
         state_next.cnt = '0;
      end else if (state_reg.cnt >= PERIOD - `GPMC_CNT_W'(1)) begin
         state_next.cnt = '0;
         state_next.tick = 1'b1;
      end else begin
         state_next.cnt = state_reg.cnt + `GPMC_CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign tick = state_reg.tick;
endmodule
`default_nettype wire

// File: core/gpmc_core.sv
// Purpose: power-mode manager: full, idle and deep idle with wake logic
// Assumes: wake detector and host line pins are asynchronous
// Notes:   mean current and config come from same-clock logic
//
// Contract
// - full mode is the default; measures, refreshes, decides mode changes
// - enter idle only when idle enabled and mean current below threshold
// - run ADC offset calibration after qualifying idle, before entering
// - idle modes measure and refresh at a slower periodic rate
// - leave idle on current at or above threshold or wake detector firing
// - deep idle also stops the high-frequency oscillator
// - delay zero: host command sets flag; deep idle entered from idle
// - delay above zero: count down in idle, deep idle at zero
// - leave deep idle on any host line activity
// - on waking from deep idle, stall host line low up to 4 ms
`timescale 1ns/1ps
`default_nettype none
`include "gpmc_map.svh"
module gpmc_core
   import gpmc_pkg::*;
#(
   parameter logic [`GPMC_CNT_W-1:0] STRETCH_CYC =
      `GPMC_CNT_W'(`GPMC_STRETCH_CYC),
   parameter logic [`GPMC_CNT_W-1:0] SETTLE_CYC =
      `GPMC_CNT_W'(`GPMC_OSC_SETTLE_CYC),
   parameter logic [`GPMC_CNT_W-1:0] FULL_PER_CYC =
      `GPMC_CNT_W'(`GPMC_FULL_PER_CYC),
   parameter logic [`GPMC_CNT_W-1:0] IDLE_PER_CYC =
      `GPMC_CNT_W'(`GPMC_IDLE_PER_CYC),
   parameter logic [`GPMC_CNT_W-1:0] TICK_CYC =
      `GPMC_CNT_W'(`GPMC_TICK_CYC)
) (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    resetn,
   // configuration and measurements
   input  wire gpmc_cfg_type            cfg,
   input  wire logic [`GPMC_CUR_W-1:0]  mean_current_reading,
   input  wire logic                    cal_done,
   input  wire logic                    deep_idle_set_cmd,
   // asynchronous pins
   input  wire logic                    wake_det,
   input  wire logic                    host_line_in,
   // status and control out
   output var  gpmc_stat_type           stat
);
   typedef struct packed {
      gpmc_mode_type           mode;
      logic [`GPMC_CNT_W-1:0]  per_cnt;
      logic [`GPMC_CNT_W-1:0]  wait_cnt;
      logic [`GPMC_DLY_W-1:0]  dly_cnt;
      logic [1:0]              wake_sync;
      logic [1:0]              line_sync;
      logic                    line_prev;
      gpmc_stat_type           stat;
   } gpmc_core_state_type;

   gpmc_core_state_type state_reg, state_next;
   logic                dly_tick;
   logic                cur_low;
   logic                idle_like;
   logic                line_act;
   logic [`GPMC_CNT_W-1:0] period;

   gpmc_tick #(
      .PERIOD (TICK_CYC)
   ) u_tick (
      .clk    (clk),
      .resetn (resetn),
      .clear  (state_reg.mode != GPMC_IDLE),
      .tick   (dly_tick)
   );

   always_comb begin
      state_next = state_reg;
      cur_low   = mean_current_reading < cfg.low_cur_thresh;
      idle_like = (state_reg.mode == GPMC_IDLE) ||
                  (state_reg.mode == GPMC_DEEP);
      // an edge either way on the line counts as host activity
      line_act  = state_reg.line_sync[1] ^ state_reg.line_prev;
      period    = idle_like ? IDLE_PER_CYC : FULL_PER_CYC;
      state_next.wake_sync = {state_reg.wake_sync[0], wake_det};
      state_next.line_sync = {state_reg.line_sync[0], host_line_in};
      state_next.line_prev = state_reg.line_sync[1];
      state_next.stat.cal_start   = 1'b0;
      state_next.stat.meas_strobe = 1'b0;

      // periodic measurement and refresh, slow in both idle modes; paused
      // only while the oscillator restarts
      if (state_reg.mode != GPMC_WAKE) begin
         if (state_reg.per_cnt >= period - `GPMC_CNT_W'(1)) begin
            state_next.per_cnt = '0;
            state_next.stat.meas_strobe = 1'b1;
         end else begin
            state_next.per_cnt = state_reg.per_cnt + `GPMC_CNT_W'(1);
         end
      end

      // command sets the flag; set wins over the clear on wake below
      if (deep_idle_set_cmd && cfg.deep_idle_delay == '0) begin
         state_next.stat.deep_idle_flag = 1'b1;
      end

      case (state_reg.mode)
         GPMC_FULL: begin
            if (cfg.idle_en && cur_low) begin
               state_next.mode = GPMC_CAL;
               state_next.stat.cal_start = 1'b1;
            end
         end
         GPMC_CAL: begin
            if (!(cfg.idle_en && cur_low)) begin
               state_next.mode = GPMC_FULL;
            end else if (cal_done) begin
               state_next.mode    = GPMC_IDLE;
               state_next.per_cnt = '0;
               state_next.dly_cnt = cfg.deep_idle_delay;
            end
         end
         GPMC_IDLE: begin
            if (!cur_low || state_reg.wake_sync[1]) begin
               state_next.mode    = GPMC_FULL;
               state_next.per_cnt = '0;
            end else if (cfg.deep_idle_delay == '0) begin
               if (state_reg.stat.deep_idle_flag) begin
                  state_next.mode = GPMC_DEEP;
               end
            end else if (state_reg.dly_cnt == '0) begin
               state_next.mode = GPMC_DEEP;
            end else if (dly_tick) begin
               state_next.dly_cnt = state_reg.dly_cnt - `GPMC_DLY_W'(1);
            end
         end
         GPMC_DEEP: begin
            // current events also end deep idle; oscillator restarts first
            if (line_act || !cur_low || state_reg.wake_sync[1]) begin
               state_next.mode     = GPMC_WAKE;
               state_next.wait_cnt = '0;
            end
         end
         GPMC_WAKE: begin
            // settle time is bounded by the stretch limit
            state_next.wait_cnt = state_reg.wait_cnt + `GPMC_CNT_W'(1);
            if (state_reg.wait_cnt >= SETTLE_CYC - `GPMC_CNT_W'(1) ||
                state_reg.wait_cnt >= STRETCH_CYC - `GPMC_CNT_W'(1)) begin
               state_next.mode    = GPMC_FULL;
               state_next.per_cnt = '0;
               if (!(deep_idle_set_cmd && cfg.deep_idle_delay == '0)) begin
                  state_next.stat.deep_idle_flag = 1'b0;
               end
            end
         end
         default: begin
            state_next.mode = GPMC_FULL;
         end
      endcase

      state_next.stat.mode_full = (state_next.mode == GPMC_FULL) ||
                                  (state_next.mode == GPMC_CAL);
      state_next.stat.mode_idle = state_next.mode == GPMC_IDLE;
      state_next.stat.mode_deep = state_next.mode == GPMC_DEEP;
      state_next.stat.hf_osc_en = state_next.mode != GPMC_DEEP;
      // hold the line low while the oscillator comes back
      state_next.stat.line_hold_oe_n = state_next.mode != GPMC_WAKE;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg      <= '0;
         state_reg.mode <= GPMC_FULL;
         state_reg.stat.mode_full      <= 1'b1;
         state_reg.stat.hf_osc_en      <= 1'b1;
         state_reg.stat.line_hold_oe_n <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign stat = state_reg.stat;
endmodule
`default_nettype wire

// File: dv/gpmc_core_monitor.sv
// Purpose: port assertions of the power-mode controller
// Assumes: one clock, async active-low reset
// Notes:   hold_cnt measures the wake stretch
`timescale 1ns/1ps
`default_nettype none
`include "gpmc_map.svh"
module gpmc_core_monitor
   import gpmc_pkg::*;
#(
   parameter logic [`GPMC_CNT_W-1:0] STRETCH_CYC =
      `GPMC_CNT_W'(`GPMC_STRETCH_CYC),
   parameter logic [`GPMC_CNT_W-1:0] SETTLE_CYC  =
      `GPMC_CNT_W'(`GPMC_OSC_SETTLE_CYC)
) (
   // clock and reset
   input wire logic                    clk,
   input wire logic                    resetn,
   // inputs
   input wire gpmc_cfg_type            cfg,
   input wire logic [`GPMC_CUR_W-1:0]  mean_current_reading,
   input wire logic                    cal_done,
   input wire logic                    deep_idle_set_cmd,
   input wire logic                    wake_det,
   input wire logic                    host_line_in,
   // outputs
   input wire gpmc_stat_type           stat
);
   logic                   qual_q;
   logic [`GPMC_CNT_W-1:0] hold_cnt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         qual_q   <= 1'h0;
         hold_cnt <= 24'h000000;
      end else begin
         qual_q   <= cfg.idle_en &&
                     (mean_current_reading < cfg.low_cur_thresh);
         hold_cnt <= stat.line_hold_oe_n ? 24'h000000 :
                     hold_cnt + 24'h000001;
      end
   end
   a_deep_osc_off: assert property (stat.mode_deep |->
      !stat.hf_osc_en) else $error("oscillator running in deep idle");
   a_idle_after_cal: assert property ($rose(stat.mode_idle) |->
      $past(cal_done)) else $error("idle entered without calibration");
   a_cal_qualified: assert property (stat.cal_start |-> qual_q)
      else $error("calibration started unqualified");
   a_idle_exit_cur: assert property (stat.mode_idle &&
      mean_current_reading > cfg.low_cur_thresh |-> ##[1:2] !stat.mode_idle)
      else $error("idle kept with high current");
   a_wake_exit: assert property ((stat.mode_idle && wake_det) [*3]
      |-> ##[1:2] !stat.mode_idle) else $error("idle kept on wake");
   a_deep_entry: assert property ($rose(stat.mode_deep) |->
      $past(stat.mode_idle) &&
      (cfg.deep_idle_delay != 16'h0000 || $past(stat.deep_idle_flag)))
      else $error("deep idle entered without cause");
   a_cmd_sets_flag: assert property (deep_idle_set_cmd &&
      cfg.deep_idle_delay == 16'h0000 |=> stat.deep_idle_flag)
      else $error("deep idle flag not set");
   a_line_wakes: assert property (stat.mode_deep &&
      host_line_in != $past(host_line_in) |-> ##[1:6] !stat.mode_deep)
      else $error("deep idle kept on line activity");
   a_stretch_max: assert property (hold_cnt <= STRETCH_CYC)
      else $error("line stretch too long");
   a_settle_wait: assert property ($rose(stat.line_hold_oe_n) |->
      hold_cnt >= SETTLE_CYC - 24'h000001) else $error("settle too short");
   c_idle: cover property ($rose(stat.mode_idle));
   c_deep: cover property ($rose(stat.mode_deep));
   c_hold: cover property ($fell(stat.line_hold_oe_n));
endmodule
`default_nettype wire

// File: dv/gpmc_host_model.sv
// Purpose: host on the serial line, open drain with pull-up
// Assumes: start is a one-cycle request from the bench
// Notes:   waits out any stretch before sending bits
`timescale 1ns/1ps
`default_nettype none
module gpmc_host_model (
   // clock
   input  wire logic clk,
   // bench control
   input  wire logic start,
   output var  logic busy,
   // shared line
   input  wire logic line_hold_oe_n,
   output wire logic line
);
   logic drive_low;
   assign line = !drive_low && line_hold_oe_n;
   initial begin
      drive_low = 1'h0;
      busy      = 1'h0;
      forever begin
         @(posedge clk iff start);
         busy      <= 1'h1;
         drive_low <= 1'h1;
         repeat (2) @(posedge clk);
         drive_low <= 1'h0;
         repeat (5) @(posedge clk);
         while (!line_hold_oe_n) @(posedge clk);
         repeat (4) @(posedge clk) drive_low <= !drive_low;
         busy <= 1'h0;
      end
   end
endmodule
`default_nettype wire

// File: dv/tb_gpmc_core.sv
// Purpose: self-checking bench of the power-mode controller
// Assumes: shortened counts set at the instance
// Notes:   one task per scenario
`timescale 1ns/1ps
`default_nettype none
module tb_gpmc_core;
   import gpmc_pkg::*;
   logic          clk, resetn, cal_done, cmd, wake, go, busy, line;
   logic [15:0]   cur;
   gpmc_cfg_type  cfg;
   gpmc_stat_type stat;
   int            fails, n_tests, n;
   gpmc_core #(.STRETCH_CYC(24'h000028), .SETTLE_CYC(24'h000014),
      .FULL_PER_CYC(24'h00000A), .IDLE_PER_CYC(24'h000032),
      .TICK_CYC(24'h000005)) uut (.clk(clk), .resetn(resetn), .cfg(cfg),
      .mean_current_reading(cur), .cal_done(cal_done),
      .deep_idle_set_cmd(cmd), .wake_det(wake), .host_line_in(line),
      .stat(stat));
   gpmc_host_model host (.clk(clk), .start(go), .busy(busy),
      .line_hold_oe_n(stat.line_hold_oe_n), .line(line));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic meas(input int span);
      n = 0;
      repeat (span) begin
         cyc(1);
         if (stat.meas_strobe === 1'h1) n++;
      end
   endtask
   task automatic pulse_cmd;
      @(posedge clk) cmd <= 1'h1;
      @(posedge clk) cmd <= 1'h0;
   endtask
   task automatic go_idle;
      int k;
      @(posedge clk);
      cfg.idle_en <= 1'h1;
      cur         <= 16'h0010;
      for (k = 0; k < 50 && stat.cal_start !== 1'h1; k++) cyc(1);
      check(stat.cal_start, 8'h01);
      cyc(3);
      check(stat.mode_idle, 8'h00);
      @(posedge clk) cal_done <= 1'h1;
      @(posedge clk) cal_done <= 1'h0;
      cyc(2);
      check(stat.mode_idle, 8'h01);
   endtask
   task automatic t_full;
      check({stat.mode_full, stat.mode_idle, stat.mode_deep, stat.hf_osc_en,
         stat.line_hold_oe_n}, 8'h13);
      meas(40);
      check(n, 8'h04);
      check(stat.mode_full, 8'h01);
      $display("test full done");
   endtask
   task automatic t_idle;
      go_idle();
      meas(100);
      check(n, 8'h02);
      @(posedge clk) cur <= 16'h0200;
      cyc(4);
      check(stat.mode_full, 8'h01);
      go_idle();
      @(posedge clk) wake <= 1'h1;
      cyc(6);
      check(stat.mode_full, 8'h01);
      @(posedge clk);
      wake        <= 1'h0;
      cfg.idle_en <= 1'h0;
      $display("test idle done");
   endtask
   task automatic t_deep;
      int k;
      go_idle();
      pulse_cmd();
      cyc(3);
      check({stat.mode_deep, stat.hf_osc_en}, 8'h02);
      @(posedge clk) go <= 1'h1;
      @(posedge clk) go <= 1'h0;
      for (k = 0; k < 10 && stat.line_hold_oe_n !== 1'h0; k++) cyc(1);
      check({stat.mode_deep, stat.hf_osc_en}, 8'h01);
      check(stat.line_hold_oe_n, 8'h00);
      for (k = 0; k < 100 && busy !== 1'h0; k++) cyc(1);
      check({stat.mode_full, stat.deep_idle_flag}, 8'h02);
      @(posedge clk) cfg.idle_en <= 1'h0;
      $display("test deep done");
   endtask
   task automatic t_timer;
      @(posedge clk) cfg.deep_idle_delay <= 16'h0003;
      pulse_cmd();
      cyc(2);
      check(stat.deep_idle_flag, 8'h00);
      go_idle();
      cyc(8);
      check(stat.mode_deep, 8'h00);
      cyc(20);
      check(stat.mode_deep, 8'h01);
      meas(100);
      check(n, 8'h02);
      $display("test timer done");
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      tally_and_finish();
   end
   initial begin
      {resetn, cal_done, cmd, wake, go} = 5'h00;
      cfg = '{1'h0, 16'h0100, 16'h0000};
      cur = 16'h0200;
      repeat (5) @(posedge clk);
      resetn <= 1'h1;
      cyc(1);
      t_full();
      t_idle();
      t_deep();
      t_timer();
      tally_and_finish();
   end
endmodule
bind gpmc_core gpmc_core_monitor #(.STRETCH_CYC(STRETCH_CYC),
   .SETTLE_CYC(SETTLE_CYC)) mon (.clk(clk), .resetn(resetn), .cfg(cfg),
   .mean_current_reading(mean_current_reading), .cal_done(cal_done),
   .deep_idle_set_cmd(deep_idle_set_cmd), .wake_det(wake_det),
   .host_line_in(host_line_in), .stat(stat));
`default_nettype wire
